// >>> logic/sajw_params.svh
// Constants for the sleep, always-on and jack wake block
`ifndef SAJW_PARAMS_SVH
`define SAJW_PARAMS_SVH
// Reset values
`define SAJW_CLAMP_SEL_RST 3'h0
`define SAJW_CORE_CFG_RST 8'h00
// Width of the core-domain configuration word
`define SAJW_CORE_W 8
// Clamp select codes
`define SAJW_CLAMP_OFF 3'h0
`define SAJW_CLAMP_A_HI 3'h1
`define SAJW_CLAMP_A_LO 3'h2
`define SAJW_CLAMP_B_HI 3'h3
`define SAJW_CLAMP_B_LO 3'h4
`define SAJW_CLAMP_AND 3'h5
`define SAJW_CLAMP_OR 3'h6
`define SAJW_CLAMP_ON 3'h7
`endif

// >>> logic/sajw_pkg.sv
// Types for the sleep, always-on and jack wake block
package sajw_pkg;
	typedef enum logic [1:0] {SAJW_AWAKE, SAJW_ASLEEP, SAJW_WAKING} sajw_pwr_t;
endpackage

// >>> logic/sajw_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module sajw_sync (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic pin_in,
	output logic      level_out
);
	logic [2:0] stage_reg;
	logic [2:0] stage_next;
	logic       level_reg;
	logic       level_next;

	// Next state: shift, update only when stages two and three agree
	always_comb begin
		stage_next = {stage_reg[1:0], pin_in};
		level_next = level_reg;
		if (stage_reg[1] == stage_reg[2]) begin
			level_next = stage_reg[2];
		end
	end

	// Registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			stage_reg <= 3'h0;
			level_reg <= 1'b0;
		end else begin
			stage_reg <= stage_next;
			level_reg <= level_next;
		end
	end

	assign level_out = level_reg;
endmodule // sajw_sync

// >>> logic/sajw_top.sv
// Sleep control and always-on jack detect with interrupt
// Summary of operation
// (R1) Core supply loss enters sleep state
// (R2) Jack pin change raises interrupt in sleep
// (R3) Always-on registers keep values through sleep
// (R4) No register access while asleep
// (R5) Core-domain inputs ignored while asleep
// (R6) Core-domain outputs float while asleep
// (R7) Drivers and keepers off while asleep
// (R8) Interrupt normally low in sleep
// (R9) Only jack activity asserts interrupt asleep
// (R10) Sleep interrupt holds until wake-up
// (R11) Only core supply return wakes device
// (R12) Host asserts regulator enable to wake
// (R13) Host stops clocks before sleep; the host model and bench keep clk running in sleep
// (R14) Host stops register access before sleep
// (R15) Jack status follows jack pins when enabled
// (R16) Clamp status from selectable jack logic
// (R17) Jack and clamp statuses feed interrupts
// (R18) Jack interrupt logic stays always-on
// (R19) Wake-up resets core logic, keeps always-on
`timescale 1ns/1ps
`include "sajw_params.svh"
module sajw_top (
	input  wire logic                     clk,
	input  wire logic                     sys_rst,
	input  wire logic                     core_supply,
	input  wire logic                     regulator_enable_pin,
	input  wire logic                     jack_detect_in_a,
	input  wire logic                     jack_detect_in_b,
	input  wire logic                     jack_enable,
	input  wire logic [2:0]               clamp_logic_select,
	input  wire logic                     irq_src_en_a,
	input  wire logic                     irq_src_en_b,
	input  wire logic                     irq_src_en_clamp,
	input  wire logic                     cfg_wr,
	input  wire logic                     irq_clear,
	input  wire logic                     core_irq_event,
	input  wire logic [`SAJW_CORE_W-1:0]  core_pin_in,
	input  wire logic [`SAJW_CORE_W-1:0]  core_pin_out_val,
	output logic                          asleep,
	output logic                          jack_status_a,
	output logic                          jack_status_b,
	output logic                          clamp_status,
	output logic                          irq_req,
	output logic [2:0]                    irq_flags,
	output logic [2:0]                    clamp_sel_rd,
	output logic                          cfg_wr_refused,
	output logic [`SAJW_CORE_W-1:0]       core_pin_cfg,
	output logic [`SAJW_CORE_W-1:0]       core_pin_out,
	output logic [`SAJW_CORE_W-1:0]       core_pin_oe,
	output logic                          keeper_en
);
	// ====================================================
	// Pin synchronisers
	logic pin_a_s;
	logic pin_b_s;
	logic supply_s;

	sajw_sync u_sync_a (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.pin_in    (jack_detect_in_a),
		.level_out (pin_a_s)
	);
	sajw_sync u_sync_b (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.pin_in    (jack_detect_in_b),
		.level_out (pin_b_s)
	);
	sajw_sync u_sync_sup (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.pin_in    (core_supply),
		.level_out (supply_s)
	);

	// ====================================================
	// Clamp function
	function automatic logic clamp_fn(input logic [2:0] sel, input logic a, input logic b);
		case (sel)
			`SAJW_CLAMP_OFF:  clamp_fn = 1'b0;
			`SAJW_CLAMP_A_HI: clamp_fn = a;
			`SAJW_CLAMP_A_LO: clamp_fn = ~a;
			`SAJW_CLAMP_B_HI: clamp_fn = b;
			`SAJW_CLAMP_B_LO: clamp_fn = ~b;
			`SAJW_CLAMP_AND:  clamp_fn = a & b;
			`SAJW_CLAMP_OR:   clamp_fn = a | b;
			default:          clamp_fn = 1'b1;
		endcase
	endfunction

	// ====================================================
	// Power state machine
	sajw_pkg::sajw_pwr_t pwr_reg;
	sajw_pkg::sajw_pwr_t pwr_next;

	// Sleep on supply loss, wake only on supply return
	always_comb begin
		pwr_next = pwr_reg;
		case (pwr_reg)
			sajw_pkg::SAJW_AWAKE: begin
				if (!supply_s) begin
					pwr_next = sajw_pkg::SAJW_ASLEEP; // [R1]
				end
			end
			sajw_pkg::SAJW_ASLEEP: begin
				if (supply_s) begin
					pwr_next = sajw_pkg::SAJW_WAKING; // [R11] [R12]
				end
			end
			sajw_pkg::SAJW_WAKING: begin
				pwr_next = supply_s ? sajw_pkg::SAJW_AWAKE : sajw_pkg::SAJW_ASLEEP;
			end
			default: pwr_next = sajw_pkg::SAJW_ASLEEP;
		endcase
	end

	// Sleep flag registered so the port comes straight from a flip-flop
	logic asleep_reg;
	logic asleep_next;
	assign asleep_next = (pwr_next != sajw_pkg::SAJW_AWAKE);

	// Power state and sleep flag registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pwr_reg    <= sajw_pkg::SAJW_ASLEEP;
			asleep_reg <= 1'b1;
		end else begin
			pwr_reg    <= pwr_next;
			asleep_reg <= asleep_next;
		end
	end

	logic sleeping;
	logic core_live;
	assign sleeping  = (pwr_reg != sajw_pkg::SAJW_AWAKE);
	assign core_live = (pwr_next == sajw_pkg::SAJW_AWAKE) && (pwr_reg == sajw_pkg::SAJW_AWAKE);

	// ====================================================
	// Always-on state: clamp select, jack status, flags, sleep irq
	logic [2:0] clamp_sel_reg;
	logic [2:0] clamp_sel_next;
	logic       jsa_reg;
	logic       jsa_next;
	logic       jsb_reg;
	logic       jsb_next;
	logic       clamp_reg;
	logic       clamp_next;
	logic [2:0] flags_reg;
	logic [2:0] flags_next;
	logic       slirq_reg;
	logic       slirq_next;
	logic       irq_reg;
	logic       irq_next;
	logic       refused_reg;
	logic       refused_next;
	logic [2:0] edges;
	logic [2:0] src_en;

	assign src_en = {irq_src_en_clamp, irq_src_en_b, irq_src_en_a};

	always_comb begin
		clamp_sel_next = clamp_sel_reg;
		refused_next   = 1'b0;
		// Writes only while awake; refused while asleep
		if (cfg_wr) begin
			if (sleeping) begin
				refused_next = 1'b1; // [R4] [R14]
			end else begin
				clamp_sel_next = clamp_logic_select;
			end
		end
		jsa_next   = jack_enable ? pin_a_s : 1'b0; // [R15]
		jsb_next   = jack_enable ? pin_b_s : 1'b0; // [R15]
		clamp_next = clamp_fn(clamp_sel_reg, jsa_reg, jsb_reg); // [R16]
		// Both edges of each status are events
		edges = {clamp_next ^ clamp_reg, jsb_next ^ jsb_reg, jsa_next ^ jsa_reg} & src_en;
		// Set wins over clear; no clear while asleep
		flags_next = flags_reg;
		if (irq_clear && !sleeping) begin
			flags_next = 3'h0;
		end
		flags_next = flags_next | edges; // [R17] [R18]
		// Sleep irq latches on jack events, releases after wake
		slirq_next = slirq_reg;
		if (sleeping && (|edges)) begin
			slirq_next = 1'b1; // [R2] [R10]
		end else if (pwr_reg == sajw_pkg::SAJW_AWAKE && irq_clear) begin
			slirq_next = 1'b0;
		end
		// From the sleep-entry edge on, only the sleep irq drives the pin
		if (pwr_next != sajw_pkg::SAJW_AWAKE) begin
			irq_next = slirq_next; // [R8] [R9]
		end else begin
			irq_next = (|flags_next) | slirq_next | core_irq_event;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			clamp_sel_reg <= `SAJW_CLAMP_SEL_RST;
			jsa_reg       <= 1'b0;
			jsb_reg       <= 1'b0;
			clamp_reg     <= 1'b0;
			flags_reg     <= 3'h0;
			slirq_reg     <= 1'b0;
			irq_reg       <= 1'b0;
			refused_reg   <= 1'b0;
		end else begin
			clamp_sel_reg <= clamp_sel_next; // [R3]
			jsa_reg       <= jsa_next;
			jsb_reg       <= jsb_next;
			clamp_reg     <= clamp_next;
			flags_reg     <= flags_next;
			slirq_reg     <= slirq_next;
			irq_reg       <= irq_next;
			refused_reg   <= refused_next;
		end
	end

	// ====================================================
	// Core-domain logic: reset by sleep, inputs ignored, outputs off
	logic [`SAJW_CORE_W-1:0] ccfg_reg;
	logic [`SAJW_CORE_W-1:0] ccfg_next;
	logic [`SAJW_CORE_W-1:0] cout_reg;
	logic [`SAJW_CORE_W-1:0] cout_next;
	logic [`SAJW_CORE_W-1:0] coe_reg;
	logic [`SAJW_CORE_W-1:0] coe_next;
	logic                    keep_reg;
	logic                    keep_next;

	always_comb begin
		if (!core_live) begin
			ccfg_next = `SAJW_CORE_CFG_RST; // [R5] [R19]
			cout_next = `SAJW_CORE_CFG_RST;
			coe_next  = `SAJW_CORE_CFG_RST; // [R6] [R7]
			keep_next = 1'b0; // [R7]
		end else begin
			ccfg_next = core_pin_in;
			cout_next = core_pin_out_val;
			coe_next  = {`SAJW_CORE_W{1'b1}};
			keep_next = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ccfg_reg <= `SAJW_CORE_CFG_RST;
			cout_reg <= `SAJW_CORE_CFG_RST;
			coe_reg  <= `SAJW_CORE_CFG_RST;
			keep_reg <= 1'b0;
		end else begin
			ccfg_reg <= ccfg_next;
			cout_reg <= cout_next;
			coe_reg  <= coe_next;
			keep_reg <= keep_next;
		end
	end

	// ====================================================
	// Outputs
	assign asleep         = asleep_reg;
	assign jack_status_a  = jsa_reg;
	assign jack_status_b  = jsb_reg;
	assign clamp_status   = clamp_reg;
	assign irq_req        = irq_reg;
	assign irq_flags      = flags_reg;
	assign clamp_sel_rd   = clamp_sel_reg;
	assign cfg_wr_refused = refused_reg;
	assign core_pin_cfg   = ccfg_reg;
	assign core_pin_out   = cout_reg;
	assign core_pin_oe    = coe_reg;
	assign keeper_en      = keep_reg;

	// ====================================================
	// Assertions
	sequence s_sleep_irq;
		sleeping && irq_reg;
	endsequence

	chk_supply_sleep: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
		(pwr_reg == sajw_pkg::SAJW_AWAKE && !supply_s) |=> sleeping)
		else $error("no sleep after supply loss");
	chk_wake_supply: assert property (@(posedge clk) disable iff (sys_rst) // [R11]
		(sleeping && !supply_s) |=> sleeping)
		else $error("wake without supply");
	chk_irq_hold: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
		s_sleep_irq |=> irq_reg)
		else $error("sleep irq released before wake");
	chk_irq_cause: assert property (@(posedge clk) disable iff (sys_rst) // [R9]
		(sleeping && $rose(irq_reg) && $past(sleeping)) |-> $past(|edges))
		else $error("sleep irq without jack event");
	chk_no_write: assert property (@(posedge clk) disable iff (sys_rst) // [R4]
		(sleeping && cfg_wr) |=> $stable(clamp_sel_reg) && cfg_wr_refused)
		else $error("write taken in sleep");
	chk_oe_off: assert property (@(posedge clk) disable iff (sys_rst) // [R6]
		$past(sleeping) |-> (coe_reg == 8'h00) && !keeper_en)
		else $error("core pins driven in sleep");
	chk_in_ignored: assert property (@(posedge clk) disable iff (sys_rst) // [R5]
		$past(sleeping) |-> (ccfg_reg == 8'h00))
		else $error("core input seen in sleep");
	chk_jack_follow: assert property (@(posedge clk) disable iff (sys_rst) // [R15]
		jack_enable |=> jsa_reg == $past(pin_a_s) && jsb_reg == $past(pin_b_s))
		else $error("jack status not following");
	chk_jack_irq: assert property (@(posedge clk) disable iff (sys_rst) // [R2]
		(sleeping && (|edges)) |=> irq_reg ##1 irq_reg)
		else $error("jack event missed in sleep");
	chk_clamp_fn: assert property (@(posedge clk) disable iff (sys_rst) // [R16]
		1'b1 |=> clamp_reg == clamp_fn($past(clamp_sel_reg), $past(jsa_reg), $past(jsb_reg)))
		else $error("clamp status wrong");
endmodule // sajw_top

// >>> tb/sajw_host.sv
// Host processor model driving the regulator enable and the core supply
`timescale 1ns/1ps
module sajw_host (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic irq_req,
	input  wire logic sleep_req,
	input  wire logic auto_wake,
	output logic      regulator_enable_pin,
	output logic      core_supply
);
	logic [3:0] ramp_reg;

	// Enable drops on request, rises again when the interrupt is seen while auto_wake is set
	always @(posedge clk) begin
		if (sys_rst) begin
			regulator_enable_pin <= 1'b1;
		end else if (sleep_req) begin
			regulator_enable_pin <= 1'b0;
		end else if (auto_wake && irq_req) begin
			regulator_enable_pin <= 1'b1;
		end
	end

	// Supply follows the enable after a short ramp
	always @(posedge clk) begin
		ramp_reg <= sys_rst ? 4'h0 : {ramp_reg[2:0], regulator_enable_pin};
	end
	assign core_supply = ramp_reg[3];
endmodule // sajw_host

// >>> tb/testbench.sv
// Self-checking bench for the sleep control and jack wake block
`timescale 1ns/1ps
module testbench;
	logic       clk = 1'b0, sys_rst = 1'b1, reg_en, supply;
	logic       sleep_req = 1'b0, auto_wake = 1'b0, core_ev = 1'b0;
	logic       jack_a = 1'b0, jack_b = 1'b0, jack_en = 1'b0;
	logic       cfg_wr = 1'b0, irq_clear = 1'b0, en_a = 1'b0, en_b = 1'b0, en_c = 1'b0;
	logic [2:0] sel = 3'h0, flags, sel_rd;
	logic [7:0] pin_in = 8'h00, pin_val = 8'h00, pin_cfg, pin_out, pin_oe;
	logic       asleep, st_a, st_b, clamp, irq, refused, keeper;
	int         failures = 0, compares = 0, cycles = 0;

	always #2 clk = ~clk;

	sajw_host host_u (.clk(clk), .sys_rst(sys_rst), .irq_req(irq), .sleep_req(sleep_req),
		.auto_wake(auto_wake), .regulator_enable_pin(reg_en), .core_supply(supply));

	sajw_top dut_u (.clk(clk), .sys_rst(sys_rst), .core_supply(supply),
		.regulator_enable_pin(reg_en), .jack_detect_in_a(jack_a), .jack_detect_in_b(jack_b),
		.jack_enable(jack_en), .clamp_logic_select(sel), .irq_src_en_a(en_a),
		.irq_src_en_b(en_b), .irq_src_en_clamp(en_c), .cfg_wr(cfg_wr), .irq_clear(irq_clear),
		.core_irq_event(core_ev), .core_pin_in(pin_in), .core_pin_out_val(pin_val),
		.asleep(asleep), .jack_status_a(st_a), .jack_status_b(st_b), .clamp_status(clamp),
		.irq_req(irq), .irq_flags(flags), .clamp_sel_rd(sel_rd), .cfg_wr_refused(refused),
		.core_pin_cfg(pin_cfg), .core_pin_out(pin_out), .core_pin_oe(pin_oe),
		.keeper_en(keeper));

	// Compare one value and count it
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Counts, verdict and end of run
	task automatic results();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Bounded wait for the sleep flag
	task automatic wait_lvl(input logic lvl);
		int n;
		n = 0;
		while (asleep !== lvl && n < 200) begin
			@(negedge clk);
			n++;
		end
	endtask

	// Reference clamp function
	function automatic int mdl_clamp(int code, int a, int b);
		case (code)
			0: return 0;
			1: return a;
			2: return 1 - a;
			3: return b;
			4: return 1 - b;
			5: return a & b;
			6: return a | b;
			default: return 1;
		endcase
	endfunction

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			failures++;
			results();
		end
	end

	initial begin
		void'($urandom(32'h27a7_438f));
		tick(8);
		sys_rst = 1'b0;
		wait_lvl(1'b0);
		check("asleep", 8'(asleep), 8'h00);
		jack_en = 1'b1;
		// Every clamp code with random jack levels
		for (int c = 0; c < 8; c++) begin
			sel = 3'(c);
			jack_a = 1'($urandom_range(1));
			jack_b = 1'($urandom_range(1));
			pin_in = 8'($urandom);
			pin_val = 8'($urandom);
			cfg_wr = 1'b1;
			tick(1);
			cfg_wr = 1'b0;
			tick(10);
			check("clamp_sel_rd", 8'(sel_rd), 8'(c));
			check("jack_status_a", 8'(st_a), 8'(jack_a));
			check("jack_status_b", 8'(st_b), 8'(jack_b));
			check("clamp_status", 8'(clamp), 8'(mdl_clamp(c, jack_a, jack_b)));
			check("core_pin_cfg", pin_cfg, pin_in);
			check("core_pin_out", pin_out, pin_val);
			check("core_pin_oe", pin_oe, 8'hff);
			check("keeper_en", 8'(keeper), 8'h01);
		end
		$display("clamp test done");
		// Awake interrupt from jack a and clamp
		sel = 3'h1;
		cfg_wr = 1'b1;
		en_a = 1'b1;
		en_c = 1'b1;
		tick(1);
		cfg_wr = 1'b0;
		tick(3);
		irq_clear = 1'b1;
		tick(1);
		irq_clear = 1'b0;
		tick(10);
		check("irq_req", 8'(irq), 8'h00);
		jack_a = ~jack_a;
		tick(10);
		check("irq_flags", 8'(flags), 8'h05);
		check("irq_req", 8'(irq), 8'h01);
		irq_clear = 1'b1;
		tick(1);
		irq_clear = 1'b0;
		en_c = 1'b0;
		tick(2);
		check("irq_req", 8'(irq), 8'h00);
		$display("awake interrupt test done");
		// Sleep entry after accesses have stopped
		sleep_req = 1'b1;
		tick(1);
		sleep_req = 1'b0;
		wait_lvl(1'b1);
		tick(2);
		check("asleep", 8'(asleep), 8'h01);
		check("core_pin_oe", pin_oe, 8'h00);
		check("keeper_en", 8'(keeper), 8'h00);
		sel = 3'h6;
		cfg_wr = 1'b1;
		tick(1);
		check("cfg_wr_refused", 8'(refused), 8'h01);
		cfg_wr = 1'b0;
		core_ev = 1'b1;
		pin_in = ~pin_in;
		tick(10);
		check("irq_req", 8'(irq), 8'h00);
		check("core_pin_cfg", pin_cfg, 8'h00);
		check("clamp_sel_rd", 8'(sel_rd), 8'h01);
		core_ev = 1'b0;
		jack_a = ~jack_a;
		tick(10);
		check("irq_req", 8'(irq), 8'h01);
		tick(60);
		check("irq_req", 8'(irq), 8'h01);
		check("asleep", 8'(asleep), 8'h01);
		$display("sleep test done");
		// Host wakes the device on the interrupt
		auto_wake = 1'b1;
		wait_lvl(1'b0);
		auto_wake = 1'b0;
		tick(2);
		check("asleep", 8'(asleep), 8'h00);
		check("irq_req", 8'(irq), 8'h01);
		check("clamp_sel_rd", 8'(sel_rd), 8'h01);
		check("irq_flag_a", 8'(flags[0]), 8'h01);
		check("core_pin_oe", pin_oe, 8'hff);
		check("keeper_en", 8'(keeper), 8'h01);
		irq_clear = 1'b1;
		tick(1);
		irq_clear = 1'b0;
		tick(2);
		check("irq_req", 8'(irq), 8'h00);
		$display("wake test done");
		// Source b interrupt, then statuses held low when disabled
		en_a = 1'b0;
		en_b = 1'b1;
		jack_b = ~jack_b;
		tick(10);
		check("irq_flags", 8'(flags), 8'h02);
		jack_a = 1'b1;
		jack_b = 1'b1;
		jack_en = 1'b0;
		tick(10);
		check("jack_status_a", 8'(st_a), 8'h00);
		check("jack_status_b", 8'(st_b), 8'h00);
		$display("enable test done");
		results();
	end
endmodule // testbench
